// file: hw/dmas_slice.sv
// Dual/quad product add-subtract sum slice with selectable stage clocking
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module dmas_slice
	import dmas_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic [3:0]           addr_i,
	input  wire logic [31:0]          wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic      [31:0]          rdata_o,
	input  wire logic [NSRC-1:0]      shared_clock_source,
	input  wire logic [NSRC-1:0]      shared_clock_enable,
	input  wire logic [NSRC-1:0]      shared_reset_source,
	input  wire logic [3:0][OP_W-1:0] op_a_i,
	input  wire logic [3:0][OP_W-1:0] op_b_i,
	input  wire logic                 dyn_sub_i,
	input  wire logic                 dyn_signed_i,
	output logic      [ACC_W-1:0]     result_o,
	output logic                      overflow_o
);
	////////////////////////////////////////////////////////////////////////////
	logic             rst_meta_reg;
	logic             rst_sync_n;
	logic [NSRC-1:0]  csync1_reg;
	logic [NSRC-1:0]  csync2_reg;
	logic [NSRC-1:0]  cprev_reg;
	logic [NSRC-1:0]  src_edge;
	logic [NSTG-1:0]  ld;
	logic [NSTG-1:0]  clr;
	logic [NSTG-1:0]  stg_en;
	dmas_sel_t        sel [NSTG];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n   <= rst_meta_reg;
		end
	end

	// Foreign clocks are sampled; edge taken after two flops only
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			csync1_reg <= 4'h0;
			csync2_reg <= 4'h0;
			cprev_reg  <= 4'h0;
		end else begin
			csync1_reg <= shared_clock_source;
			csync2_reg <= csync1_reg;
			cprev_reg  <= csync2_reg;
		end
	end
	assign src_edge = csync2_reg & ~cprev_reg;

	////////////////////////////////////////////////////////////////////////////
	logic [7:0]       ctrl_reg, ctrl_next;
	logic [17:0]      sel_reg, sel_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [31:0]      rdata_reg, rdata_next;
	logic             ov_reg, ov_next;
	dmas_mode_t       mode;

	assign mode = dmas_mode_t'(ctrl_reg[CTRL_QUAD]);
	assign stg_en = ctrl_reg[CTRL_OUT_EN:CTRL_IN_EN];

	genvar s;
	generate
		for (s = 0; s < NSTG; s++) begin : g_stg
			assign sel[s] = dmas_sel_t'(sel_reg[s*SEL_STRIDE +: SEL_STRIDE]);
			assign ld[s]  = src_edge[sel[s].clk] & shared_clock_enable[sel[s].ce];
			assign clr[s] = shared_reset_source[sel[s].rst];
		end
	endgenerate

	always_comb begin
		ctrl_next  = ctrl_reg;
		sel_next   = sel_reg;
		rdata_next = 32'h00000000;
		cnt_next   = cnt_reg + {15'h0000, ov_reg};
		if (wr_i) begin
			if (addr_i == ADDR_CTRL) begin
				ctrl_next = wdata_i[7:0];
			end else if (addr_i == ADDR_SEL) begin
				sel_next = wdata_i[17:0];
			end else if (addr_i == ADDR_STAT) begin
				cnt_next = CNT_RST;
			end
		end
		if (rd_i) begin
			if (addr_i == ADDR_CTRL) begin
				rdata_next = {24'h000000, ctrl_reg};
			end else if (addr_i == ADDR_SEL) begin
				rdata_next = {14'h0000, sel_reg};
			end else if (addr_i == ADDR_STAT) begin
				rdata_next = {15'h0000, ov_reg, cnt_reg};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_reg  <= CTRL_RST;
			sel_reg   <= SEL_RST;
			cnt_reg   <= CNT_RST;
			rdata_reg <= 32'h00000000;
		end else begin
			ctrl_reg  <= ctrl_next;
			sel_reg   <= sel_next;
			cnt_reg   <= cnt_next;
			rdata_reg <= rdata_next;
		end
	end
	assign rdata_o = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	dmas_ops_t            ops_c, in_reg, in_next, ops_s;
	dmas_prod_t           prod_c, pipe_reg, pipe_next, prod_s;
	logic signed [SUM_W-1:0] sum01, sum23, sum_c;
	logic [ACC_W-1:0]     addend, acc_sum, out_reg, out_next;
	logic                 ov_cond;

	always_comb begin
		ops_c.a   = op_a_i;
		ops_c.b   = op_b_i;
		// Static mode ignores the dynamic pins entirely
		ops_c.sub = ctrl_reg[CTRL_DYN] ? dyn_sub_i : ctrl_reg[CTRL_SUB];
		ops_c.sgn = ctrl_reg[CTRL_DYN] ? dyn_signed_i : ctrl_reg[CTRL_SIGNED];
		in_next = in_reg;
		if (clr[STG_IN]) begin
			in_next = '0;
		end else if (ld[STG_IN]) begin
			in_next = ops_c;
		end
		ops_s = stg_en[STG_IN] ? in_reg : ops_c;
	end

	// Operands already carry full width; sign bit only sets interpretation
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			prod_c.p[i] = PROD_W'(
				$signed({ops_s.sgn & ops_s.a[i][OP_W-1], ops_s.a[i]}) *
				$signed({ops_s.sgn & ops_s.b[i][OP_W-1], ops_s.b[i]}));
		end
		prod_c.sgn = ops_s.sgn;
		prod_c.sub = ops_s.sub;
		pipe_next = pipe_reg;
		if (clr[STG_PIPE]) begin
			pipe_next = '0;
		end else if (ld[STG_PIPE]) begin
			pipe_next = prod_c;
		end
		prod_s = stg_en[STG_PIPE] ? pipe_reg : prod_c;
	end

	always_comb begin
		sum01 = prod_s.sub ?
			SUM_W'($signed(prod_s.p[0])) - SUM_W'($signed(prod_s.p[1])) :
			SUM_W'($signed(prod_s.p[0])) + SUM_W'($signed(prod_s.p[1]));
		sum23 = prod_s.sub ?
			SUM_W'($signed(prod_s.p[2])) - SUM_W'($signed(prod_s.p[3])) :
			SUM_W'($signed(prod_s.p[2])) + SUM_W'($signed(prod_s.p[3]));
		sum_c = (mode == DMAS_QUAD) ? sum01 + sum23 : sum01;
		addend  = ACC_W'(sum_c);
		if (!prod_s.sgn) begin
			addend = {{(ACC_W-SUM_W){1'b0}}, sum_c};
		end
		// Plain wrapping add, no saturation
		acc_sum = out_reg + addend;
		if (prod_s.sgn) begin
			ov_cond = (out_reg[ACC_W-1] == addend[ACC_W-1]) &&
				(acc_sum[ACC_W-1] != out_reg[ACC_W-1]);
		end else begin
			ov_cond = acc_sum < out_reg;
		end
		out_next = out_reg;
		ov_next  = 1'b0;
		if (clr[STG_OUT]) begin
			out_next = '0;
		end else if (ld[STG_OUT]) begin
			out_next = ctrl_reg[CTRL_ACCUM] ? acc_sum : addend;
			ov_next  = ctrl_reg[CTRL_ACCUM] & stg_en[STG_OUT] & ov_cond;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			in_reg   <= '0;
			pipe_reg <= '0;
			out_reg  <= '0;
			ov_reg   <= 1'b0;
		end else begin
			in_reg   <= in_next;
			pipe_reg <= pipe_next;
			out_reg  <= out_next;
			ov_reg   <= ov_next;
		end
	end

	// Bypassed output stage still loads out_reg but is not seen; result follows the sum
	assign result_o   = stg_en[STG_OUT] ? out_reg : addend;
	assign overflow_o = ov_reg;

	////////////////////////////////////////////////////////////////////////////
	sequence s_acc_load;
		ld[STG_OUT] && !clr[STG_OUT] && stg_en[STG_OUT] && ctrl_reg[CTRL_ACCUM];
	endsequence

	AST_OV_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		overflow_o |=> !overflow_o)
		else $error("overflow longer than one cycle");
	AST_OV_UNSIGNED: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		s_acc_load ##0 (!prod_s.sgn && (acc_sum < out_reg)) |=> overflow_o)
		else $error("unsigned wrap not flagged");
	AST_OV_SIGNED: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		s_acc_load ##0 (prod_s.sgn && !out_reg[ACC_W-1] && !addend[ACC_W-1]
		&& acc_sum[ACC_W-1]) |=> overflow_o)
		else $error("signed wrap not flagged");
	AST_OV_CAUSE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		overflow_o |-> $past(ld[STG_OUT]) && $past(ctrl_reg[CTRL_ACCUM]))
		else $error("overflow without accumulate load");
	AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		s_acc_load |=> out_reg == $past(out_reg) + $past(addend))
		else $error("accumulator did not wrap");
	AST_DUAL: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		(stg_en == 3'b000 && mode == DMAS_DUAL && !ops_c.sgn && !ops_c.sub
		&& op_a_i[1] == 18'h00000)
		|-> result_o == ACC_W'(op_a_i[0]) * ACC_W'(op_b_i[0]))
		else $error("dual mode result wrong");
	AST_QUAD: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		(stg_en == 3'b000 && mode == DMAS_QUAD && !ops_c.sgn && !ops_c.sub
		&& op_a_i[0] == 18'h00000 && op_a_i[1] == 18'h00000 && op_a_i[3] == 18'h00000)
		|-> result_o == ACC_W'(op_a_i[2]) * ACC_W'(op_b_i[2]))
		else $error("quad sum misses second pair");
	AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		clr[STG_OUT] && stg_en[STG_OUT] |=> result_o == '0)
		else $error("output stage not cleared");
	AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		!ld[STG_IN] && !clr[STG_IN] |=> $stable(in_reg))
		else $error("input stage moved without its clock");
	AST_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ld[STG_PIPE] |-> csync2_reg[sel[STG_PIPE].clk] && !cprev_reg[sel[STG_PIPE].clk]
		&& shared_clock_enable[sel[STG_PIPE].ce])
		else $error("pipeline loaded off its clock edge");
	AST_DYN: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ctrl_reg[CTRL_DYN] && !stg_en[STG_IN] |-> ops_s.sub == dyn_sub_i
		&& ops_s.sgn == dyn_signed_i)
		else $error("dynamic controls ignored");
endmodule

// file: include/dmas_pkg.sv
// Shared constants and types for the multiply add/sub sum slice
package dmas_pkg;
	localparam int OP_W   = 18;
	localparam int EXT_W  = 19;
	localparam int PROD_W = 38;
	localparam int SUM_W  = 40;
	localparam int ACC_W  = 52;
	localparam int CNT_W  = 16;
	localparam int NSRC   = 4;
	localparam int NSTG   = 3;
	localparam int STG_IN   = 0;
	localparam int STG_PIPE = 1;
	localparam int STG_OUT  = 2;
	// Register map
	localparam logic [3:0]  ADDR_CTRL = 4'h0;
	localparam logic [3:0]  ADDR_SEL  = 4'h4;
	localparam logic [3:0]  ADDR_STAT = 4'h8;
	localparam logic [7:0]  CTRL_RST  = 8'h0e;
	localparam logic [17:0] SEL_RST   = 18'h00000;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	// Control field positions
	localparam int CTRL_QUAD   = 0;
	localparam int CTRL_IN_EN  = 1;
	localparam int CTRL_PIPE_EN = 2;
	localparam int CTRL_OUT_EN = 3;
	localparam int CTRL_DYN    = 4;
	localparam int CTRL_SUB    = 5;
	localparam int CTRL_SIGNED = 6;
	localparam int CTRL_ACCUM  = 7;
	localparam int SEL_STRIDE  = 6;

	typedef enum logic [0:0] {
		DMAS_DUAL = 1'b0,
		DMAS_QUAD = 1'b1
	} dmas_mode_t;

	typedef struct packed {
		logic [1:0] rst;
		logic [1:0] ce;
		logic [1:0] clk;
	} dmas_sel_t;

	typedef struct packed {
		logic [3:0][OP_W-1:0] a;
		logic [3:0][OP_W-1:0] b;
		logic                 sgn;
		logic                 sub;
	} dmas_ops_t;

	typedef struct packed {
		logic [3:0][PROD_W-1:0] p;
		logic                   sgn;
		logic                   sub;
	} dmas_prod_t;
endpackage

// file: tb/dmas_fabric_model.sv
// Fabric-side model: operand width extension and shared clock pulses
`timescale 1ns/10ps
module dmas_fabric_model
	import dmas_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 tick,
	input  wire logic [1:0]           tick_src,
	input  wire logic                 ext_sgn,
	input  wire logic [3:0][8:0]      nar_a,
	input  wire logic [3:0][8:0]      nar_b,
	output logic      [3:0][OP_W-1:0] op_a,
	output logic      [3:0][OP_W-1:0] op_b,
	output logic      [NSRC-1:0]      src,
	output logic                      busy
);
	logic [2:0] cnt_reg = 3'h0;
	logic [1:0] sel_reg = 2'h0;
	////////////////////////////////////////////////////////////////
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// Upper bits are zeros or copies of bit 8
			op_a[i] = {{9{ext_sgn & nar_a[i][8]}}, nar_a[i]};
			op_b[i] = {{9{ext_sgn & nar_b[i][8]}}, nar_b[i]};
		end
	end
	////////////////////////////////////////////////////////////////
	// High three, low three; idle low so no stray edge reaches a stage
	always_ff @(posedge clk_sys) begin
		if (tick && cnt_reg == 3'h0) begin
			cnt_reg <= 3'h6;
			sel_reg <= tick_src;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end
	end
	always_comb begin
		src = 4'h0;
		if (cnt_reg > 3'h3) begin
			src[sel_reg] = 1'b1;
		end
	end
	assign busy = (cnt_reg != 3'h0);
endmodule

// file: tb/tb_dmas_slice.sv
// Testbench for the product add/sub sum slice
`timescale 1ns/10ps
module tb_dmas_slice
	import dmas_pkg::*;
;
	logic                 clk_sys = 1'b0, rst_n = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic                 tick = 1'b0, ext_sgn = 1'b0, overflow_o, busy;
	logic                 dyn_sub_i = 1'b0, dyn_signed_i = 1'b0;
	logic [3:0]           addr_i = 4'h0;
	logic [31:0]          wdata_i = 32'h0, rdata_o;
	logic [1:0]           tick_src = 2'h0;
	logic [NSRC-1:0]      src, ce = 4'hf, rs = 4'h0;
	logic [3:0][8:0]      nar_a = {9'h011, 9'h1fa, 9'h0ff, 9'h1ff};
	logic [3:0][8:0]      nar_b = {9'h003, 9'h005, 9'h1fa, 9'h100};
	logic [3:0][OP_W-1:0] op_a, op_b;
	logic [ACC_W-1:0]     result_o, held;
	int                   miscompares = 0, num_checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	dmas_slice DUT (.clk_sys(clk_sys), .rst_n(rst_n), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .shared_clock_source(src),
		.shared_clock_enable(ce), .shared_reset_source(rs), .op_a_i(op_a), .op_b_i(op_b),
		.dyn_sub_i(dyn_sub_i), .dyn_signed_i(dyn_signed_i), .result_o(result_o),
		.overflow_o(overflow_o));
	dmas_fabric_model fab (.clk_sys(clk_sys), .tick(tick), .tick_src(tick_src),
		.ext_sgn(ext_sgn), .nar_a(nar_a), .nar_b(nar_b), .op_a(op_a), .op_b(op_b),
		.src(src), .busy(busy));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [ACC_W-1:0] e);
		chk({12'h0, result_o}, {12'h0, e});
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys);
		rd_i <= 1'b0;
		#1 chk({32'h0, rdata_o}, {32'h0, e});
	endtask
	// Waits out the whole source pulse plus the sync latency
	task automatic pulse(input logic [1:0] s);
		@(posedge clk_sys);
		tick <= 1'b1;
		tick_src <= s;
		@(posedge clk_sys);
		tick <= 1'b0;
		#1;
		for (int i = 0; i < 20 && busy; i++) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	function automatic logic [ACC_W-1:0] calc(input logic q, input logic s, input logic g);
		logic signed [ACC_W-1:0] p[4];
		logic signed [ACC_W-1:0] r;
		for (int i = 0; i < 4; i++)
			p[i] = $signed({g & op_a[i][17], op_a[i]}) * $signed({g & op_b[i][17], op_b[i]});
		r = s ? p[0] - p[1] : p[0] + p[1];
		if (q) r = r + (s ? p[2] - p[3] : p[2] + p[3]);
		return r;
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge clk_sys);
		miscompares++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(ADDR_CTRL, {24'h0, CTRL_RST});
		rd(ADDR_SEL, 32'h0);
		rd(ADDR_STAT, 32'h0);
		wr(4'hc, 32'hffffffff);
		rd(4'hc, 32'h0);
		rd(ADDR_CTRL, {24'h0, CTRL_RST});
		$display("test reset done");
		// Three stages on: new operands need three loads
		pulse(2'h0);
		rchk(52'h0);
		pulse(2'h0);
		pulse(2'h0);
		rchk(calc(1'b0, 1'b0, 1'b0));
		$display("test stages done");
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_CTRL, {24'h0, 1'b0, m[2], m[1], 4'h4, m[0]});
			@(posedge clk_sys);
			ext_sgn <= m[2];
			pulse(2'h0);
			rchk(calc(m[0], m[1], m[2]));
		end
		$display("test modes done");
		// Static bits stay clear so only the dynamic inputs decide
		wr(ADDR_CTRL, 32'h18);
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_sys);
			dyn_sub_i <= m[0];
			dyn_signed_i <= m[1];
			ext_sgn <= m[1];
			pulse(2'h0);
			rchk(calc(1'b0, m[0], m[1]));
		end
		$display("test dynamic done");
		wr(ADDR_SEL, 32'h3000);
		rd(ADDR_SEL, 32'h3000);
		held = calc(1'b0, 1'b1, 1'b1);
		@(posedge clk_sys);
		nar_a <= nar_a ^ {4{9'h0a5}};
		pulse(2'h0);
		rchk(held);
		pulse(2'h3);
		rchk(calc(1'b0, 1'b1, 1'b1));
		held = calc(1'b0, 1'b1, 1'b1);
		wr(ADDR_SEL, 32'h4000);
		@(posedge clk_sys);
		ce <= 4'hd;
		nar_b <= nar_b ^ {4{9'h05a}};
		pulse(2'h0);
		rchk(held);
		@(posedge clk_sys);
		ce <= 4'hf;
		pulse(2'h0);
		rchk(calc(1'b0, 1'b1, 1'b1));
		held = calc(1'b0, 1'b1, 1'b1);
		// Unselected reset must leave the stage alone
		wr(ADDR_SEL, 32'h20000);
		for (int k = 1; k < 3; k++) begin
			@(posedge clk_sys);
			rs <= 4'h1 << k;
			@(posedge clk_sys);
			rs <= 4'h0;
			repeat (2) @(posedge clk_sys);
			#1 rchk(k == 2 ? 52'h0 : held);
		end
		rd(ADDR_STAT, 32'h0);
		$display("test select done");
		// Two loads into a cleared accumulator give twice the sum
		wr(ADDR_SEL, 32'h0);
		wr(ADDR_CTRL, 32'h88);
		held = calc(1'b0, 1'b0, 1'b0);
		pulse(2'h0);
		pulse(2'h0);
		rchk(held + held);
		chk({63'h0, overflow_o}, 64'h0);
		$display("test accumulate done");
		// All stages bypassed: result follows operands
		wr(ADDR_CTRL, 32'h0);
		@(posedge clk_sys);
		ext_sgn <= 1'b0;
		nar_a <= {9'h000, 9'h013, 9'h000, 9'h000};
		repeat (2) @(posedge clk_sys);
		#1 rchk(calc(1'b0, 1'b0, 1'b0));
		wr(ADDR_CTRL, 32'h1);
		@(posedge clk_sys);
		#1 rchk(calc(1'b1, 1'b0, 1'b0));
		$display("test bypass done");
		tally_and_finish;
	end
endmodule
